// ==== inc/lbmr_pkg.sv ====
// constants for the laser bias and monitor register bank
package lbmr_pkg;
  localparam logic [7:0] REG_BIAS_CODE_UPPER = 8'h0F;
  localparam logic [7:0] REG_MONITOR_SELECT_AND_BIAS_LOW = 8'h10;
  localparam logic [7:0] REG_BIAS_FAULT_THRESHOLD = 8'h11;
  localparam logic [7:0] REG_POWER_FAULT_THRESHOLD = 8'h12;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int PD_SEL_BIT = 6;
  localparam int BIAS_SEL_BIT = 5;
  localparam int BIAS_LOW_MSB = 1;
  localparam int BIAS_CODE_W = 10;
  localparam int TARGET_W = 14;
  // photodiode current per bias step, in units of 0.25 uA
  localparam logic [3:0] GAIN_RANGE_00 = 4'h3;
  localparam logic [3:0] GAIN_RANGE_01 = 4'h2;
  localparam logic [3:0] GAIN_RANGE_1X = 4'hC;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h08;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  typedef enum logic [8:0] {
    S_IDLE    = 9'h001,
    S_DEV     = 9'h002,
    S_DEV_ACK = 9'h004,
    S_REG     = 9'h008,
    S_REG_ACK = 9'h010,
    S_WR      = 9'h020,
    S_WR_ACK  = 9'h040,
    S_RD      = 9'h080,
    S_RD_ACK  = 9'h100
  } lbmr_state_e;
endpackage

// ==== hdl/lbmr_regs.sv ====
// laser bias code, monitor select and fault threshold registers behind a two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
module lbmr_regs #(
  parameter logic [6:0] DEV_ADDR = lbmr_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] photodiode_range_select_i,
  input wire logic [7:0] pd_monitor_level_i,
  input wire logic [7:0] bias_monitor_level_i,
  output logic [lbmr_pkg::BIAS_CODE_W-1:0] laser_bias_code_o,
  output logic digital_pd_monitor_sel_o,
  output logic digital_bias_monitor_sel_o,
  output logic [7:0] bias_fault_threshold_o,
  output logic [7:0] power_fault_threshold_o,
  output logic bias_fault_o,
  output logic power_fault_o,
  output logic [lbmr_pkg::TARGET_W-1:0] pd_current_target_o
);
  // pin synchronisers: three flops, a level counts once flops two and three agree
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic [2:0] next_scl_sync;
  logic [2:0] next_sda_sync;
  logic next_scl_f;
  logic next_sda_f;

  always_comb begin
    next_scl_sync = {scl_sync[1:0], scl_i};
    next_sda_sync = {sda_sync[1:0], sda_i};
    next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  // sda moving while scl stays high marks start and stop
  assign start_c = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

  // protocol engine and register file
  lbmr_pkg::lbmr_state_e state;
  lbmr_pkg::lbmr_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rd_dir;
  logic next_rd_dir;
  logic master_nack;
  logic next_master_nack;
  logic oe;
  logic next_oe;
  logic [7:0] bias_code_upper;
  logic [7:0] monitor_select_and_bias_low;
  logic [7:0] bias_fault_threshold;
  logic [7:0] power_fault_threshold;
  logic [7:0] next_bias_code_upper;
  logic [7:0] next_monitor_select_and_bias_low;
  logic [7:0] next_bias_fault_threshold;
  logic [7:0] next_power_fault_threshold;
  logic [7:0] rd_data;

  // unmapped offsets read as zero and swallow writes
  always_comb begin
    unique case (ptr)
      lbmr_pkg::REG_BIAS_CODE_UPPER: rd_data = bias_code_upper;
      lbmr_pkg::REG_MONITOR_SELECT_AND_BIAS_LOW: rd_data = monitor_select_and_bias_low;
      lbmr_pkg::REG_BIAS_FAULT_THRESHOLD: rd_data = bias_fault_threshold;
      lbmr_pkg::REG_POWER_FAULT_THRESHOLD: rd_data = power_fault_threshold;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rd_dir = rd_dir;
    next_master_nack = master_nack;
    next_oe = oe;
    next_bias_code_upper = bias_code_upper;
    next_monitor_select_and_bias_low = monitor_select_and_bias_low;
    next_bias_fault_threshold = bias_fault_threshold;
    next_power_fault_threshold = power_fault_threshold;
    if (stop_c) begin
      next_state = lbmr_pkg::S_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      next_state = lbmr_pkg::S_DEV;
      next_bit_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        lbmr_pkg::S_DEV, lbmr_pkg::S_REG, lbmr_pkg::S_WR: begin
          next_shreg = {shreg[6:0], sda_f};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        lbmr_pkg::S_RD_ACK: next_master_nack = sda_f;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        lbmr_pkg::S_DEV: begin
          if (bit_cnt == lbmr_pkg::BITS_PER_BYTE) begin
            if (shreg[7:1] == DEV_ADDR) begin
              next_rd_dir = shreg[0];
              next_oe = 1'b1;
              next_state = lbmr_pkg::S_DEV_ACK;
            end else begin
              next_state = lbmr_pkg::S_IDLE;
            end
          end
        end
        lbmr_pkg::S_REG: begin
          if (bit_cnt == lbmr_pkg::BITS_PER_BYTE) begin
            next_ptr = shreg;
            next_oe = 1'b1;
            next_state = lbmr_pkg::S_REG_ACK;
          end
        end
        lbmr_pkg::S_WR: begin
          if (bit_cnt == lbmr_pkg::BITS_PER_BYTE) begin
            unique case (ptr)
              lbmr_pkg::REG_BIAS_CODE_UPPER: next_bias_code_upper = shreg;
              lbmr_pkg::REG_MONITOR_SELECT_AND_BIAS_LOW: next_monitor_select_and_bias_low = shreg;
              lbmr_pkg::REG_BIAS_FAULT_THRESHOLD: next_bias_fault_threshold = shreg;
              lbmr_pkg::REG_POWER_FAULT_THRESHOLD: next_power_fault_threshold = shreg;
              default: ;
            endcase
            next_ptr = ptr + 8'h01;
            next_oe = 1'b1;
            next_state = lbmr_pkg::S_WR_ACK;
          end
        end
        lbmr_pkg::S_DEV_ACK: begin
          next_bit_cnt = 4'h0;
          if (rd_dir) begin
            next_shreg = rd_data;
            next_ptr = ptr + 8'h01;
            next_oe = ~rd_data[7];
            next_state = lbmr_pkg::S_RD;
          end else begin
            next_oe = 1'b0;
            next_state = lbmr_pkg::S_REG;
          end
        end
        lbmr_pkg::S_REG_ACK, lbmr_pkg::S_WR_ACK: begin
          next_bit_cnt = 4'h0;
          next_oe = 1'b0;
          next_state = lbmr_pkg::S_WR;
        end
        lbmr_pkg::S_RD: begin
          if (bit_cnt == lbmr_pkg::LAST_TX_BIT) begin
            next_oe = 1'b0;
            next_state = lbmr_pkg::S_RD_ACK;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shreg = {shreg[6:0], 1'b0};
            next_oe = ~shreg[6];
          end
        end
        lbmr_pkg::S_RD_ACK: begin
          // a nack from the master ends the burst
          if (!master_nack) begin
            next_bit_cnt = 4'h0;
            next_shreg = rd_data;
            next_ptr = ptr + 8'h01;
            next_oe = ~rd_data[7];
            next_state = lbmr_pkg::S_RD;
          end else begin
            next_state = lbmr_pkg::S_IDLE;
          end
        end
        lbmr_pkg::S_IDLE: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= lbmr_pkg::S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rd_dir <= 1'b0;
      master_nack <= 1'b1;
      oe <= 1'b0;
      bias_code_upper <= lbmr_pkg::RESET_VALUE;
      monitor_select_and_bias_low <= lbmr_pkg::RESET_VALUE;
      bias_fault_threshold <= lbmr_pkg::RESET_VALUE;
      power_fault_threshold <= lbmr_pkg::RESET_VALUE;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rd_dir <= next_rd_dir;
      master_nack <= next_master_nack;
      oe <= next_oe;
      bias_code_upper <= next_bias_code_upper;
      monitor_select_and_bias_low <= next_monitor_select_and_bias_low;
      bias_fault_threshold <= next_bias_fault_threshold;
      power_fault_threshold <= next_power_fault_threshold;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe;

  logic [9:0] bias_code;
  assign bias_code = {bias_code_upper, monitor_select_and_bias_low[lbmr_pkg::BIAS_LOW_MSB:0]};
  assign laser_bias_code_o = bias_code;
  assign digital_pd_monitor_sel_o = monitor_select_and_bias_low[lbmr_pkg::PD_SEL_BIT];
  assign digital_bias_monitor_sel_o = monitor_select_and_bias_low[lbmr_pkg::BIAS_SEL_BIT];
  assign bias_fault_threshold_o = bias_fault_threshold;
  assign power_fault_threshold_o = power_fault_threshold;

  // fault compare and loop target
  logic bias_fault;
  logic power_fault;
  logic [lbmr_pkg::TARGET_W-1:0] pd_target;
  logic next_bias_fault;
  logic next_power_fault;
  logic [lbmr_pkg::TARGET_W-1:0] next_pd_target;
  logic [3:0] gain;

  always_comb begin
    // an analog-selected monitor never raises a digital fault
    next_bias_fault = digital_bias_monitor_sel_o & (bias_monitor_level_i >= bias_fault_threshold);
    next_power_fault = digital_pd_monitor_sel_o & (pd_monitor_level_i >= power_fault_threshold);
    unique case (photodiode_range_select_i)
      2'h0: gain = lbmr_pkg::GAIN_RANGE_00;
      2'h1: gain = lbmr_pkg::GAIN_RANGE_01;
      default: gain = lbmr_pkg::GAIN_RANGE_1X;
    endcase
    next_pd_target = {4'h0, bias_code} * {10'h000, gain};
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bias_fault <= 1'b0;
      power_fault <= 1'b0;
      pd_target <= '0;
    end else begin
      bias_fault <= next_bias_fault;
      power_fault <= next_power_fault;
      pd_target <= next_pd_target;
    end
  end

  assign bias_fault_o = bias_fault;
  assign power_fault_o = power_fault;
  assign pd_current_target_o = pd_target;
endmodule
`default_nettype wire

// ==== verif/lbmr_regs_checker.sv ====
// port assertions for the laser bias and monitor register bank
`timescale 1ns/1ps
`default_nettype none
module lbmr_regs_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic [1:0] photodiode_range_select_i,
  input wire logic [7:0] pd_monitor_level_i,
  input wire logic [7:0] bias_monitor_level_i,
  input wire logic [lbmr_pkg::BIAS_CODE_W-1:0] laser_bias_code_o,
  input wire logic digital_pd_monitor_sel_o,
  input wire logic digital_bias_monitor_sel_o,
  input wire logic [7:0] bias_fault_threshold_o,
  input wire logic [7:0] power_fault_threshold_o,
  input wire logic bias_fault_o,
  input wire logic power_fault_o,
  input wire logic [lbmr_pkg::TARGET_W-1:0] pd_current_target_o
);
  logic [3:0] gain;
  logic [13:0] exp_tgt;
  assign gain = photodiode_range_select_i[1] ? lbmr_pkg::GAIN_RANGE_1X :
    (photodiode_range_select_i[0] ? lbmr_pkg::GAIN_RANGE_01 : lbmr_pkg::GAIN_RANGE_00);
  assign exp_tgt = 14'(laser_bias_code_o) * 14'(gain);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // registered compare, so the fault trails its inputs by one clock
  bias_fault_a: assert property (bias_fault_o == $past(digital_bias_monitor_sel_o &&
    bias_monitor_level_i >= bias_fault_threshold_o)) else $error("bias fault wrong");
  power_fault_a: assert property (power_fault_o == $past(digital_pd_monitor_sel_o &&
    pd_monitor_level_i >= power_fault_threshold_o)) else $error("power fault wrong");
  bias_sel_gate_a: assert property ($rose(bias_fault_o) |-> $past(digital_bias_monitor_sel_o))
    else $error("bias fault with analog monitor");
  pd_sel_gate_a: assert property ($rose(power_fault_o) |-> $past(digital_pd_monitor_sel_o))
    else $error("power fault with analog monitor");
  target_gain_a: assert property (pd_current_target_o == $past(exp_tgt))
    else $error("target not code times gain");
  // a long high on the clock pin means no byte can end, so no register output may update
  code_hold_a: assert property (scl_i [*8] |-> $stable(laser_bias_code_o))
    else $error("bias code changed with bus idle");
  thresh_hold_a: assert property (scl_i [*8] |-> $stable({bias_fault_threshold_o, power_fault_threshold_o}))
    else $error("threshold changed with bus idle");
  sel_hold_a: assert property (scl_i [*8] |-> $stable({digital_pd_monitor_sel_o, digital_bias_monitor_sel_o}))
    else $error("monitor select changed with bus idle");
  cover property ($rose(bias_fault_o));
  cover property ($rose(power_fault_o));
  cover property (photodiode_range_select_i[1] && laser_bias_code_o != 10'h000);
endmodule
bind lbmr_regs lbmr_regs_checker u_lbmr_regs_checker (.sys_clk_i, .nrst_i, .scl_i, .photodiode_range_select_i,
  .pd_monitor_level_i, .bias_monitor_level_i, .laser_bias_code_o, .digital_pd_monitor_sel_o,
  .digital_bias_monitor_sel_o, .bias_fault_threshold_o, .power_fault_threshold_o, .bias_fault_o,
  .power_fault_o, .pd_current_target_o);
`default_nettype wire

// ==== verif/lbmr_regs_bench.sv ====
// self-checking bench for the laser bias and monitor register bank
`timescale 1ns/1ps
`default_nettype none
module lbmr_regs_bench;
  logic sys_clk_i = 0, nrst_i = 0, scl = 1, msda = 1;
  logic [1:0] rng = 0;
  logic [7:0] pdl = 0, bsl = 0;
  logic [8:0] sh = 0;
  logic sda_o, sda_oe_o, bf, pf, dps, dbs;
  logic [9:0] code;
  logic [7:0] bth, pth;
  logic [13:0] tgt;
  logic [31:0] seed = 32'h60B9;
  logic [15:0] q[$];
  int fail_count = 0, n_compared = 0, sel = 0;
  string item_name[6] = '{"bus_bits", "bias_code", "monitor_sel", "thresholds", "faults", "pd_target"};
  event smp;
  // open drain wire with pull-up: low if either side pulls
  wire sda_w = msda & ~(sda_oe_o & ~sda_o);
  localparam logic [6:0] DEV = lbmr_pkg::DEV_ADDR_DEFAULT;
  lbmr_regs u_lbmr_regs (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .photodiode_range_select_i(rng), .pd_monitor_level_i(pdl), .bias_monitor_level_i(bsl),
    .laser_bias_code_o(code), .digital_pd_monitor_sel_o(dps), .digital_bias_monitor_sel_o(dbs),
    .bias_fault_threshold_o(bth), .power_fault_threshold_o(pth), .bias_fault_o(bf), .power_fault_o(pf),
    .pd_current_target_o(tgt));
  always #20 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic note(input int s, input logic [15:0] e);
    q.push_back(e);
    sel = s;
    -> smp;
    #1;
  endtask
  always @(smp) begin : watch
    logic [15:0] e, g;
    e = q.pop_front();
    case (sel)
      0: g = {7'h00, sh};
      1: g = {6'h00, code};
      2: g = {14'h0000, dps, dbs};
      3: g = {bth, pth};
      4: g = {14'h0000, bf, pf};
      default: g = {2'h0, tgt};
    endcase
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", item_name[sel], e, g);
    end
  end
  // phases of at least two clocks so the pin filters settle
  task automatic bt(input logic b);
    msda = b;
    wt(4);
    scl = 1;
    wt(5);
    sh = {sh[7:0], sda_w};
    scl = 0;
    wt(2);
  endtask
  task automatic xb(input logic [7:0] d, input logic [8:0] e);
    for (int i = 7; i >= 0; i--) bt(d[i]);
    bt(1'b1);
    note(0, {7'h00, e});
  endtask
  task automatic st;
    msda = 1;
    wt(3);
    scl = 1;
    wt(5);
    msda = 0;
    wt(5);
    scl = 0;
    wt(2);
  endtask
  task automatic sp;
    msda = 0;
    wt(3);
    scl = 1;
    wt(5);
    msda = 1;
    wt(5);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    st;
    xb({DEV, 1'b0}, {DEV, 2'b00});
    xb(r, {r, 1'b0});
    xb(d, {d, 1'b0});
    sp;
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e);
    st;
    xb({DEV, 1'b0}, {DEV, 2'b00});
    xb(r, {r, 1'b0});
    st;
    xb({DEV, 1'b1}, {DEV, 2'b10});
    xb(8'hFF, {e, 1'b1});
    sp;
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin : main
    logic [7:0] r[4];
    logic [3:0] g;
    wt(20);
    nrst_i = 1;
    wt(6);
    for (int i = 0; i < 4; i++) rd(lbmr_pkg::REG_BIAS_CODE_UPPER + 8'(i), 8'h00);
    note(3, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        seed = xs(seed);
        r[i] = seed[7:0];
        wr(lbmr_pkg::REG_BIAS_CODE_UPPER + 8'(i), r[i]);
      end
      for (int i = 0; i < 4; i++) rd(lbmr_pkg::REG_BIAS_CODE_UPPER + 8'(i), r[i]);
      note(1, {6'h00, r[0], r[1][1:0]});
      note(2, {14'h0000, r[1][6], r[1][5]});
      note(3, {r[2], r[3]});
      for (int j = 0; j < 4; j++) begin
        rng = 2'(j);
        wt(2);
        g = rng[1] ? lbmr_pkg::GAIN_RANGE_1X : (rng[0] ? lbmr_pkg::GAIN_RANGE_01 : lbmr_pkg::GAIN_RANGE_00);
        note(5, {2'h0, 14'({r[0], r[1][1:0]}) * 14'(g)});
      end
    end
    rd(8'h13, 8'h00);
    st;
    xb({DEV ^ 7'h01, 1'b0}, {DEV ^ 7'h01, 2'b01});
    sp;
    wr(lbmr_pkg::REG_BIAS_FAULT_THRESHOLD, 8'h80);
    wr(lbmr_pkg::REG_POWER_FAULT_THRESHOLD, 8'h40);
    bsl = 8'h81;
    pdl = 8'h41;
    for (int s = 0; s < 4; s++) begin
      wr(lbmr_pkg::REG_MONITOR_SELECT_AND_BIAS_LOW, {1'b0, s[1], s[0], 5'h00});
      note(4, {14'h0000, s[0], s[1]});
    end
    for (int i = 0; i < 3; i++) begin
      bsl = 8'h7F + 8'(i);
      pdl = 8'h3F + 8'(i);
      wt(2);
      note(4, {14'h0000, i > 0, i > 0});
    end
    end_of_test;
  end
  initial begin : watchdog
    wt(60000);
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
